// ==== rtl/sensor_monitor_cfg.svh ====
// register offsets, field positions, reset values and codes of the control registers
// assumes inclusion by bare name from any design file that needs them
`ifndef SENSOR_MONITOR_CFG_SVH
`define SENSOR_MONITOR_CFG_SVH

// register offsets on the serial register port
`define OFS_MODE_REPORT 8'h00
`define OFS_SOFT_RESET 8'h14
`define OFS_ZERO_TRIM 8'h15
`define OFS_WRITE_KEY 8'h17
`define OFS_FUNC_SEL 8'h1C
`define OFS_INPUT_ARR 8'h24

// field positions
`define BIT_TRIGGER 0
`define BIT_FAST_BUS 2
`define KEY_MSB 3
`define FSEL_MSB 2
`define ARR_MSB 1
`define ACT_MSB 1

// reset values
`define KEY_RESET 4'h0
`define FSEL_RESET 3'h0
`define ARR_RESET 2'h0
`define BYTE_ZERO 8'h00

// unlock pattern for the reset trigger
`define UNLOCK_CODE 4'hA

// function select codes
`define FSEL_MAN_CH0_A 3'h0
`define FSEL_MAN_CH0_B 3'h1
`define FSEL_MAN_SEQ_A 3'h4
`define FSEL_MAN_SEQ_B 3'h5
`define FSEL_AUTONOMOUS 3'h6
`define FSEL_PRECISION 3'h7

// active function codes shown in the mode report
`define ACT_MANUAL 2'h0
`define ACT_AUTONOMOUS 2'h2
`define ACT_PRECISION 2'h3

// input arrangement codes
`define ARR_DUAL_A 2'h0
`define ARR_REMOTE_GND 2'h1
`define ARR_PSEUDO_DIFF 2'h2
`define ARR_DUAL_B 2'h3

`endif

// ==== rtl/sensor_monitor_pkg.sv ====
// types shared by the control register block and its crossing helpers
// assumes the constants of sensor_monitor_cfg.svh for all values
package sensor_monitor_pkg;

  // decoded operating function, one-hot
  typedef enum logic [3:0] {
    MODE_MANUAL_CH0 = 4'h1,
    MODE_MANUAL_SEQ = 4'h2,
    MODE_AUTONOMOUS = 4'h4,
    MODE_PRECISION = 4'h8
  } mode_e;

  // link side request handshake, one-hot
  typedef enum logic [1:0] {
    LINK_IDLE = 2'h1,
    LINK_WAIT = 2'h2
  } link_state_e;

  // register state of the core clock domain
  typedef struct packed {
    logic [3:0] unlockCode;
    logic [2:0] functionSelect;
    logic [1:0] inputArrangement;
    mode_e activeMode;
    logic [1:0] activeFunction;
    logic dualSingleEnded;
    logic remoteGroundSense;
    logic pseudoDifferential;
    logic [7:0] readData;
    logic ackToggle;
    logic trimStartPulse;
    logic resetNowPulse;
  } core_s;

  // state of the link clock domain
  typedef struct packed {
    link_state_e state;
    logic reqToggle;
    logic gcToggle;
    logic reqWrite;
    logic [7:0] reqAddr;
    logic [7:0] reqData;
    logic [7:0] rdata;
    logic done;
    logic busy;
  } link_s;

  // state of a toggle-to-pulse synchroniser
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic pulse;
  } pulse_sync_s;

  // state of a two flop level synchroniser
  typedef struct packed {
    logic sync1;
    logic sync2;
  } level_sync_s;

endpackage : sensor_monitor_pkg

// ==== rtl/toggle_pulse_sync.sv ====
// toggle event crossing: a toggle from another domain becomes a one-cycle pulse here
// assumes the source toggles at most once per handshake and holds its value meanwhile,
// and that reset lasts at least three cycles of the receiving clock
`timescale 1ns/100ps

module toggle_pulse_sync
  import sensor_monitor_pkg::*;
(
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic reset,
  // toggle from the far domain
  input wire logic srcToggle,
  // event pulse in this domain
  output logic pulse
);

  pulse_sync_s state_reg;
  pulse_sync_s state_next;

  // only the second flop looks at the first; the edge check uses the second
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = srcToggle;
    state_next.sync2 = state_reg.sync1;
    state_next.last = state_reg.sync2;
    state_next.pulse = state_reg.sync2 ^ state_reg.last;
    // in reset the flops keep tracking the source, so a toggle left high by the
    // far domain is not replayed as a stale event once reset goes away
    if (reset) begin
      state_next.pulse = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign pulse = state_reg.pulse;

endmodule : toggle_pulse_sync

// ==== rtl/level_sync.sv ====
// two flop synchroniser for a slow level from another domain
// assumes the level stays for several cycles of the receiving clock
`timescale 1ns/100ps

module level_sync
  import sensor_monitor_pkg::*;
(
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic reset,
  // level from the far domain
  input wire logic srcLevel,
  // synchronised level
  output logic level
);

  level_sync_s state_reg;
  level_sync_s state_next;

  // plain two stage shift
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = srcLevel;
    state_next.sync2 = state_reg.sync1;
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.sync2;

endmodule : level_sync

// ==== rtl/sensor_monitor_ctrl_regs.sv ====
// control registers of a dual channel sensor monitor: keyed soft reset, zero trim
// trigger, function selection, mode report and input arrangement
// assumes a serial bus engine on linkClk hands over byte accesses and bus speed state
//
// Operation
// - A soft reset trigger write is taken only while the unlock code holds 1010b.
// - The unlock code sits in bits 3 to 0 of the write key, is read/write, resets to zero.
// - A soft reset returns every register to default except the write key.
// - An authorised one in bit 0 of the soft reset trigger resets the device; write-only.
// - A one in bit 0 of the zero trim command starts an offset trim; write-only.
// - Function select bits 2 to 0 pick manual, manual sequenced, autonomous or precision.
// - Bit 2 of the mode report reads one while the serial bus runs in fast mode.
// - Mode report bits 1 to 0 show 00b manual, 10b autonomous, 11b precision.
// - Upper four bits of the write key read zero and are not written by the host.
// - Input arrangement bits 1 to 0 are read/write, reset to zero, higher bits read zero.
// - Input arrangement picks two single ended, remote ground or pseudo differential.
// - All registers return to default at power-up and on a general call reset.
`timescale 1ns/100ps
`include "sensor_monitor_cfg.svh"

module sensor_monitor_ctrl_regs
  import sensor_monitor_pkg::*;
(
  // core clock and power-up reset
  input wire logic clk,
  input wire logic reset,
  // link clock and its reset
  input wire logic linkClk,
  input wire logic linkReset,
  // byte access from the serial bus engine, linkClk domain
  input wire logic linkWrite,
  input wire logic linkRead,
  input wire logic [7:0] linkAddr,
  input wire logic [7:0] linkWdata,
  output logic [7:0] linkRdata,
  output logic linkDone,
  output logic linkBusy,
  // bus state from the serial bus engine, linkClk domain
  input wire logic linkFastBus,
  input wire logic linkGeneralCall,
  // configuration towards the converter
  output logic [2:0] functionSelect,
  output mode_e activeMode,
  output logic dualSingleEnded,
  output logic remoteGroundSense,
  output logic pseudoDifferential,
  // trigger pulses towards the converter
  output logic trimStartPulse,
  output logic resetNowPulse
);

  // core reset image
  localparam core_s CORE_RESET = '{
    unlockCode: `KEY_RESET,
    functionSelect: `FSEL_RESET,
    inputArrangement: `ARR_RESET,
    activeMode: MODE_MANUAL_CH0,
    activeFunction: `ACT_MANUAL,
    dualSingleEnded: 1'b1,
    remoteGroundSense: 1'b0,
    pseudoDifferential: 1'b0,
    readData: `BYTE_ZERO,
    ackToggle: 1'b0,
    trimStartPulse: 1'b0,
    resetNowPulse: 1'b0
  };

  // link reset image
  localparam link_s LINK_RESET = '{
    state: LINK_IDLE,
    reqToggle: 1'b0,
    gcToggle: 1'b0,
    reqWrite: 1'b0,
    reqAddr: `BYTE_ZERO,
    reqData: `BYTE_ZERO,
    rdata: `BYTE_ZERO,
    done: 1'b0,
    busy: 1'b0
  };

  core_s core_reg;
  core_s core_next;
  link_s link_reg;
  link_s link_next;
  logic reqPulse;
  logic generalCallPulse;
  logic ackPulse;
  logic fastBus;

  // function code to operating function
  function automatic mode_e decodeMode(input logic [2:0] sel);
    mode_e m;
    case (sel)
      `FSEL_MAN_CH0_A, `FSEL_MAN_CH0_B: m = MODE_MANUAL_CH0;
      `FSEL_MAN_SEQ_A, `FSEL_MAN_SEQ_B: m = MODE_MANUAL_SEQ;
      `FSEL_AUTONOMOUS: m = MODE_AUTONOMOUS;
      `FSEL_PRECISION: m = MODE_PRECISION;
      default: m = MODE_MANUAL_CH0; // reserved codes fall back to manual
    endcase
    return m;
  endfunction : decodeMode

  // operating function to mode report code
  function automatic logic [1:0] reportCode(input mode_e m);
    logic [1:0] c;
    case (m)
      MODE_AUTONOMOUS: c = `ACT_AUTONOMOUS;
      MODE_PRECISION: c = `ACT_PRECISION;
      default: c = `ACT_MANUAL; // both manual flavours report manual
    endcase
    return c;
  endfunction : reportCode

  // crossings: request and general call into the core, answer back to the link
  toggle_pulse_sync reqSync (
    .clk(clk),
    .reset(reset),
    .srcToggle(link_reg.reqToggle),
    .pulse(reqPulse)
  );

  toggle_pulse_sync gcSync (
    .clk(clk),
    .reset(reset),
    .srcToggle(link_reg.gcToggle),
    .pulse(generalCallPulse)
  );

  toggle_pulse_sync ackSync (
    .clk(linkClk),
    .reset(linkReset),
    .srcToggle(core_reg.ackToggle),
    .pulse(ackPulse)
  );

  level_sync fastSync (
    .clk(clk),
    .reset(reset),
    .srcLevel(linkFastBus),
    .level(fastBus)
  );

  // link side: take one access at a time, hold it until the core answers
  always_comb begin
    link_next = link_reg;
    link_next.done = 1'b0;
    if (linkGeneralCall) begin
      link_next.gcToggle = ~link_reg.gcToggle;
    end
    case (link_reg.state)
      LINK_IDLE: begin
        if (linkWrite || linkRead) begin
          link_next.reqWrite = linkWrite;
          link_next.reqAddr = linkAddr;
          link_next.reqData = linkWdata;
          link_next.reqToggle = ~link_reg.reqToggle;
          link_next.busy = 1'b1;
          link_next.state = LINK_WAIT;
        end
      end
      LINK_WAIT: begin
        // accesses arriving now are ignored; busy tells the engine so
        if (ackPulse) begin
          link_next.rdata = core_reg.readData; // stable until the next request
          link_next.done = 1'b1;
          link_next.busy = 1'b0;
          link_next.state = LINK_IDLE;
        end
      end
      default: begin
        link_next = LINK_RESET;
      end
    endcase
  end

  // link state register
  always_ff @(posedge linkClk) begin
    if (linkReset) begin
      link_reg <= LINK_RESET;
    end else begin
      link_reg <= link_next;
    end
  end

  // core side: decode the handed over access and update the registers
  always_comb begin
    core_next = core_reg;
    core_next.trimStartPulse = 1'b0;
    core_next.resetNowPulse = 1'b0;
    if (reqPulse) begin
      core_next.readData = `BYTE_ZERO;
      if (link_reg.reqWrite) begin
        case (link_reg.reqAddr)
          `OFS_SOFT_RESET: begin
            if (link_reg.reqData[`BIT_TRIGGER] &&
                core_reg.unlockCode == `UNLOCK_CODE) begin
              core_next = CORE_RESET;
              core_next.unlockCode = core_reg.unlockCode;
              core_next.resetNowPulse = 1'b1;
            end
          end
          `OFS_ZERO_TRIM: begin
            core_next.trimStartPulse = link_reg.reqData[`BIT_TRIGGER];
          end
          `OFS_WRITE_KEY: begin
            core_next.unlockCode = link_reg.reqData[`KEY_MSB:0];
          end
          `OFS_FUNC_SEL: begin
            core_next.functionSelect = link_reg.reqData[`FSEL_MSB:0];
          end
          `OFS_INPUT_ARR: begin
            core_next.inputArrangement = link_reg.reqData[`ARR_MSB:0];
          end
          default: begin
            core_next.readData = `BYTE_ZERO; // unmapped writes are dropped
          end
        endcase
      end else begin
        case (link_reg.reqAddr)
          `OFS_MODE_REPORT: begin
            core_next.readData[`BIT_FAST_BUS] = fastBus;
            core_next.readData[`ACT_MSB:0] = core_reg.activeFunction;
          end
          `OFS_WRITE_KEY: begin
            core_next.readData[`KEY_MSB:0] = core_reg.unlockCode;
          end
          `OFS_FUNC_SEL: begin
            core_next.readData[`FSEL_MSB:0] = core_reg.functionSelect;
          end
          `OFS_INPUT_ARR: begin
            core_next.readData[`ARR_MSB:0] = core_reg.inputArrangement;
          end
          default: begin
            core_next.readData = `BYTE_ZERO; // trigger and unmapped read zero
          end
        endcase
      end
      core_next.ackToggle = ~core_reg.ackToggle;
    end
    // decoded views follow the stored fields
    core_next.activeMode = decodeMode(core_next.functionSelect);
    core_next.activeFunction = reportCode(core_next.activeMode);
    core_next.dualSingleEnded = (core_next.inputArrangement == `ARR_DUAL_A) ||
                                (core_next.inputArrangement == `ARR_DUAL_B);
    core_next.remoteGroundSense = core_next.inputArrangement == `ARR_REMOTE_GND;
    core_next.pseudoDifferential = core_next.inputArrangement == `ARR_PSEUDO_DIFF;
    // general call clears everything, key included; answer toggle kept alive
    if (generalCallPulse) begin
      core_next = CORE_RESET;
      core_next.ackToggle = reqPulse ? ~core_reg.ackToggle : core_reg.ackToggle;
    end
  end

  // core state register
  always_ff @(posedge clk) begin
    if (reset) begin
      core_reg <= CORE_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  // outputs straight from the state registers
  assign linkRdata = link_reg.rdata;
  assign linkDone = link_reg.done;
  assign linkBusy = link_reg.busy;
  assign functionSelect = core_reg.functionSelect;
  assign activeMode = core_reg.activeMode;
  assign dualSingleEnded = core_reg.dualSingleEnded;
  assign remoteGroundSense = core_reg.remoteGroundSense;
  assign pseudoDifferential = core_reg.pseudoDifferential;
  assign trimStartPulse = core_reg.trimStartPulse;
  assign resetNowPulse = core_reg.resetNowPulse;

endmodule : sensor_monitor_ctrl_regs

// ==== tb/sensor_monitor_ctrl_regs_asserts.sv ====
// checker of the register block ports, bound into the design
// assumes clk and linkClk domains with synchronous active high resets
`timescale 1ns/100ps

module sensor_monitor_ctrl_regs_asserts
  import sensor_monitor_pkg::*;
(
  // clocks and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic linkReset,
  // link answer
  input wire logic linkDone,
  input wire logic linkBusy,
  // configuration and triggers
  input wire logic [2:0] functionSelect,
  input wire mode_e activeMode,
  input wire logic dualSingleEnded,
  input wire logic remoteGroundSense,
  input wire logic pseudoDifferential,
  input wire logic trimStartPulse,
  input wire logic resetNowPulse
);
  // one-hot mode expected for a function code
  function automatic mode_e modeOf(input logic [2:0] f);
    case (f)
      3'h4, 3'h5: return MODE_MANUAL_SEQ;
      3'h6: return MODE_AUTONOMOUS;
      3'h7: return MODE_PRECISION;
      default: return MODE_MANUAL_CH0;
    endcase
  endfunction : modeOf

  // trigger pulses and their effects
  property p_trim_pulse;
    @(posedge clk) disable iff (reset) trimStartPulse |=> !trimStartPulse;
  endproperty
  a_trim_pulse: assert property (p_trim_pulse) else $error("trim pulse too long");
  property p_reset_pulse;
    @(posedge clk) disable iff (reset) resetNowPulse |=> !resetNowPulse;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
  property p_soft_defaults;
    @(posedge clk) disable iff (reset) resetNowPulse |=>
      functionSelect == 3'h0 && activeMode == MODE_MANUAL_CH0 && dualSingleEnded;
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset left state");
  property p_hard_defaults;
    @(posedge clk) disable iff (reset) $fell(reset) |->
      functionSelect == 3'h0 && activeMode == MODE_MANUAL_CH0 && dualSingleEnded;
  endproperty
  a_hard_defaults: assert property (p_hard_defaults) else $error("bad power-up state");
  // mode and arrangement decode
  property p_mode_map;
    @(posedge clk) disable iff (reset) $stable(functionSelect) |-> activeMode == modeOf(functionSelect);
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("mode does not match code");
  property p_mode_onehot;
    @(posedge clk) disable iff (reset) $onehot(activeMode);
  endproperty
  a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");
  property p_arr_onehot;
    @(posedge clk) disable iff (reset)
      $onehot({dualSingleEnded, remoteGroundSense, pseudoDifferential});
  endproperty
  a_arr_onehot: assert property (p_arr_onehot) else $error("arrangement not one-hot");
  // link answer within 20 link cycles of busy rising, with busy low
  property p_link_done;
    @(posedge linkClk) disable iff (linkReset) $rose(linkBusy) |-> ##[1:20] (linkDone && !linkBusy);
  endproperty
  a_link_done: assert property (p_link_done) else $error("access not answered");
endmodule : sensor_monitor_ctrl_regs_asserts

bind sensor_monitor_ctrl_regs sensor_monitor_ctrl_regs_asserts sensor_monitor_ctrl_regs_asserts_i (
  .clk(clk), .reset(reset), .linkClk(linkClk), .linkReset(linkReset),
  .linkDone(linkDone), .linkBusy(linkBusy), .functionSelect(functionSelect),
  .activeMode(activeMode), .dualSingleEnded(dualSingleEnded),
  .remoteGroundSense(remoteGroundSense), .pseudoDifferential(pseudoDifferential),
  .trimStartPulse(trimStartPulse), .resetNowPulse(resetNowPulse)
);

// ==== tb/link_host_model.sv ====
// host model of the serial bus engine: single byte accesses on linkClk
// assumes the register block answers every taken request with linkDone
`timescale 1ns/100ps

module link_host_model (
  // link clock
  input wire logic linkClk,
  // request
  output logic linkWrite,
  output logic linkRead,
  output logic [7:0] linkAddr,
  output logic [7:0] linkWdata,
  // answer
  input wire logic [7:0] linkRdata,
  input wire logic linkDone
);
  // idle request lines
  initial begin
    linkWrite = 1'b0;
    linkRead = 1'b0;
    linkAddr = 8'h00;
    linkWdata = 8'h00;
  end

  // one access after slow plus one idle cycles; lost flags a missing answer
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input int slow, output logic [7:0] q, output logic lost);
    logic [7:0] dw;
    dw = d;
    if (wr && a == 8'h17) dw = {4'h0, d[3:0]};
    if (wr && a == 8'h1C && d[2:1] == 2'b01) dw = 8'h00;
    repeat (slow + 1) @(posedge linkClk);
    #1;
    linkWrite = wr;
    linkRead = !wr;
    linkAddr = a;
    linkWdata = dw;
    @(posedge linkClk);
    #1;
    linkWrite = 1'b0;
    linkRead = 1'b0;
    linkAddr = ~a;
    linkWdata = ~dw;
    lost = 1'b1;
    q = 8'h00;
    for (int i = 0; i < 20 && lost; i++) begin
      @(posedge linkClk);
      #1;
      if (linkDone === 1'b1) begin
        lost = 1'b0;
        q = linkRdata;
      end
    end
  endtask : access
endmodule : link_host_model

// ==== tb/testbench.sv ====
// self-checking bench of the control registers against a behavioural model
// assumes the host model for link accesses and the bound checker
`timescale 1ns/100ps

module testbench
  import sensor_monitor_pkg::*;
;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset, linkReset, linkFastBus, linkGeneralCall;
  logic linkWrite, linkRead, linkDone, linkBusy;
  logic [7:0] linkAddr, linkWdata, linkRdata;
  logic [2:0] functionSelect;
  mode_e activeMode;
  logic dualSingleEnded, remoteGroundSense, pseudoDifferential, trimStartPulse, resetNowPulse;
  int num_errors = 0;
  int cmp_count = 0;
  int nTrim = 0;
  int nReset = 0;
  int eTrim = 0;
  int eReset = 0;
  logic [3:0] mKey;
  logic [2:0] mFsel;
  logic [1:0] mArr;
  logic mFast;
  logic [7:0] offs [7] = '{8'h00, 8'h14, 8'h15, 8'h17, 8'h1C, 8'h24, 8'h3A};

  // clocks of unrelated phase
  always #5 clk = ~clk;
  always #24 linkClk = ~linkClk;

  sensor_monitor_ctrl_regs sensor_monitor_ctrl_regs_i (
    .clk(clk), .reset(reset), .linkClk(linkClk), .linkReset(linkReset),
    .linkWrite(linkWrite), .linkRead(linkRead), .linkAddr(linkAddr), .linkWdata(linkWdata),
    .linkRdata(linkRdata), .linkDone(linkDone), .linkBusy(linkBusy),
    .linkFastBus(linkFastBus), .linkGeneralCall(linkGeneralCall),
    .functionSelect(functionSelect), .activeMode(activeMode),
    .dualSingleEnded(dualSingleEnded), .remoteGroundSense(remoteGroundSense),
    .pseudoDifferential(pseudoDifferential), .trimStartPulse(trimStartPulse),
    .resetNowPulse(resetNowPulse)
  );
  link_host_model link_host_model_i (
    .linkClk(linkClk), .linkWrite(linkWrite), .linkRead(linkRead), .linkAddr(linkAddr),
    .linkWdata(linkWdata), .linkRdata(linkRdata), .linkDone(linkDone)
  );

  // trigger pulse counters, sampled mid-cycle where the pulses are settled
  always @(negedge clk) begin
    if (trimStartPulse === 1'b1) nTrim++;
    if (resetNowPulse === 1'b1) nReset++;
  end

  // expected register read value
  function automatic logic [7:0] expRd(input logic [7:0] a);
    case (a)
      8'h00: return {5'h00, mFast, mFsel[2:1] == 2'b11, mFsel == 3'h7};
      8'h17: return {4'h0, mKey};
      8'h1C: return {5'h00, mFsel};
      8'h24: return {6'h00, mArr};
      default: return 8'h00;
    endcase
  endfunction : expRd

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // access through the host model, mirrored in the model state
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic lost;
    link_host_model_i.access(w, a, d, $urandom_range(2), q, lost);
    chk({7'h00, lost}, 8'h00);
    if (!w) chk(q, expRd(a));
    if (w && a == 8'h17) mKey = d[3:0];
    if (w && a == 8'h1C) mFsel = d[2:0];
    if (w && a == 8'h24) mArr = d[1:0];
    if (w && a == 8'h15 && d[0]) eTrim++;
    if (w && a == 8'h14 && d[0] && mKey == 4'hA) begin
      eReset++;
      mFsel = 3'h0;
      mArr = 2'h0;
    end
  endtask : acc

  // read every offset and the decoded outputs
  task automatic sweep();
    foreach (offs[i]) acc(1'b0, offs[i], 8'h00);
    chk({1'b0, functionSelect, activeMode}, {1'b0, mFsel, mFsel[2] ? (mFsel[1] ? (mFsel[0]
        ? 4'h8 : 4'h4) : 4'h2) : 4'h1});
    chk({5'h00, dualSingleEnded, remoteGroundSense, pseudoDifferential},
        (mArr == 2'h1) ? 8'h02 : (mArr == 2'h2) ? 8'h01 : 8'h04);
    chk(8'(nTrim), 8'(eTrim));
    chk(8'(nReset), 8'(eReset));
  endtask : sweep

  // watchdog: about 130 accesses of at most 12 link cycles each, with margin
  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    linkReset = 1'b1;
    linkFastBus = 1'b0;
    linkGeneralCall = 1'b0;
    mKey = 4'h0;
    mFsel = 3'h0;
    mArr = 2'h0;
    mFast = 1'b0;
    void'($urandom(32'hC9DD));
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    @(posedge linkClk);
    #1 linkReset = 1'b0;
    sweep();
    $display("test power-up values done");
    for (int i = 0; i < 8; i++) begin
      if (i == 2 || i == 3) continue;
      @(posedge linkClk);
      #1 linkFastBus = i[0];
      mFast = i[0];
      acc(1'b1, 8'h1C, {5'(8'($urandom())), 3'(i)});
      acc(1'b1, 8'h24, {6'(8'($urandom())), 2'(i)});
      acc(1'b1, 8'h17, {4'h0, 4'($urandom())});
      acc(1'b1, 8'h00, 8'($urandom()));
      acc(1'b1, 8'h3A, 8'($urandom()));
      sweep();
    end
    $display("test modes and arrangement done");
    acc(1'b1, 8'h15, 8'h01);
    acc(1'b1, 8'h15, 8'hFE);
    sweep();
    $display("test trim trigger done");
    acc(1'b1, 8'h17, 8'h05);
    acc(1'b1, 8'h14, 8'h01);
    sweep();
    acc(1'b1, 8'h17, 8'h0A);
    acc(1'b1, 8'h14, 8'h01);
    sweep();
    acc(1'b1, 8'h17, 8'h00);
    acc(1'b1, 8'h14, 8'h01);
    sweep();
    $display("test keyed reset done");
    acc(1'b1, 8'h1C, 8'h07);
    acc(1'b1, 8'h17, 8'h03);
    @(posedge linkClk);
    #1 linkGeneralCall = 1'b1;
    @(posedge linkClk);
    #1 linkGeneralCall = 1'b0;
    repeat (4) @(posedge linkClk);
    mKey = 4'h0;
    mFsel = 3'h0;
    mArr = 2'h0;
    sweep();
    $display("test general call done");
    final_report();
  end
endmodule : testbench
